//--- src/lbsn_link_port.sv
// Notes on behaviour
// - Set bounce flag on single/switch, down port, request
// - Dual node clears flag: both up, no request
// - Flag set reflects tokens, else forwards them
// - Resets and renegotiate put port Disabled, Privileged
// - Hold idle while line fault, then negotiate
// - Set link up before any credit exchange
// - Send ten frame gaps before first ready pair
// - Need buffer space, send ready pair, clear owed
// - Wait remote ready pair, clear wait, then frames
// - Sync plus frame gap ends negotiation, Ready
// - Single rate: 200 idle, Enabled, gaps until Ready
// - Dual rate steps: 400/400, 200/200, 400/100, 200/300
// - Step lengths within ten percent, kept nominal
// - Each step: set rate, Disabled, timer, 200 idle
// - Sync in step: Enabled, idle replaced by gaps
// - Gap before expiry gives Ready, else next step
// - After fourth step wrap to first, endlessly
`timescale 1ns/1ps
`default_nettype none
module lbsn_link_port
  import lbsn_pkg::*;
#(
  parameter int unsigned STEP0_CYC = ms_to_cyc(STEP0_MS),
  parameter int unsigned STEP1_CYC = ms_to_cyc(STEP1_MS),
  parameter int unsigned STEP2_CYC = ms_to_cyc(STEP2_MS),
  parameter int unsigned STEP3_CYC = ms_to_cyc(STEP3_MS)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Line status pins
  input wire logic lineFault,
  input wire logic charSync,
  input wire logic otherPortOper,
  // Receive decoder strobes
  input wire logic gapRx,
  input wire logic recvReadyRx,
  input wire logic tokenRx,
  // Transmit side
  input wire logic txCharStrobe,
  input wire logic bufFree,
  output lbsn_txchar_t txChar,
  output logic rateHigh,
  output logic tokenBounceOut,
  output logic tokenForwardOut,
  // Port status
  output lbsn_pstate_t portState,
  output logic privMode,
  output logic linkUp,
  output logic creditOwed,
  output logic creditWait,
  output logic privFramesOk
);

  typedef struct packed {
    logic faultMeta;
    logic faultSync;
    logic syncMeta;
    logic syncSync;
    logic operMeta;
    logic operSync;
    lbsn_fsm_t fsm;
    logic [CNT_W-1:0] charCnt;
    lbsn_txchar_t txChar;
    lbsn_pstate_t pstate;
    logic privMode;
    logic linkUp;
    logic creditOwed;
    logic creditWait;
    logic tokenBounce;
    logic tokenBack;
    logic tokenOn;
    logic dualRate;
    lbsn_node_t nodeType;
    logic wrPend;
    logic [ADDR_W-1:0] wrAddr;
    logic [31:0] rdata;
  } lbsn_port_state_t;

  lbsn_port_state_t state_q;
  lbsn_port_state_t state_d;

  lbsn_timer_if tmrIf ();

  lbsn_step_timer #(
    .STEP0_CYC(STEP0_CYC),
    .STEP1_CYC(STEP1_CYC),
    .STEP2_CYC(STEP2_CYC),
    .STEP3_CYC(STEP3_CYC)
  ) u_step_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .tmr(tmrIf.timer)
  );

  logic busAccess;
  logic evWrite;
  logic ctrlWrite;
  logic evPost;
  logic evReset;
  logic evErp;
  logic evSetup;
  logic evBounce;
  logic evRate;
  logic enterDisabled;
  logic [31:0] statusWord;
  logic [31:0] ctrlWord;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [31:0] a);
    return a[ADDR_W-1:0];
  endfunction

  function automatic logic step_due(input logic dual, input logic expired);
    return dual && expired;
  endfunction

  assign busAccess = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign evWrite = state_q.wrPend && (state_q.wrAddr == ADDR_EVENT);
  assign ctrlWrite = state_q.wrPend && (state_q.wrAddr == ADDR_CTRL);
  assign evPost = evWrite && hwdata[EV_POWER_ON_SELF_TEST_BIT];
  assign evReset = evWrite && hwdata[EV_RESET_BIT];
  assign evErp = evWrite && hwdata[EV_ERP_BIT];
  assign evSetup = evWrite && hwdata[EV_SETUP_BIT];
  assign evBounce = hwdata[EV_BOUNCE_BIT];
  assign evRate = evSetup && (hwdata[EV_RATE_LSB +: EV_RATE_W] != '0);
  assign enterDisabled = evPost || evReset || evErp || evRate;

  // Register read words
  always_comb begin
    statusWord = RDATA_ZERO;
    statusWord[ST_FSM_LSB +: 3] = state_q.fsm;
    statusWord[ST_PSTATE_LSB +: 2] = state_q.pstate;
    statusWord[ST_STEP_LSB +: 2] = tmrIf.step;
    statusWord[ST_LINKUP_BIT] = state_q.linkUp;
    statusWord[ST_OWED_BIT] = state_q.creditOwed;
    statusWord[ST_WAIT_BIT] = state_q.creditWait;
    statusWord[ST_BOUNCE_BIT] = state_q.tokenBounce;
    statusWord[ST_PRIV_BIT] = state_q.privMode;
    statusWord[ST_FAULT_BIT] = state_q.faultSync;
    statusWord[ST_RATE_BIT] = tmrIf.rateHigh;
    ctrlWord = RDATA_ZERO;
    ctrlWord[CTRL_DUAL_BIT] = state_q.dualRate;
    ctrlWord[CTRL_TYPE_LSB +: 2] = state_q.nodeType;
  end

  always_comb begin
    state_d = state_q;
    tmrIf.restart = 1'b0;
    tmrIf.advance = 1'b0;

    // Pin synchronisers
    state_d.faultMeta = lineFault;
    state_d.faultSync = state_q.faultMeta;
    state_d.syncMeta = charSync;
    state_d.syncSync = state_q.syncMeta;
    state_d.operMeta = otherPortOper;
    state_d.operSync = state_q.operMeta;

    // Bus slave, zero wait states
    state_d.wrPend = busAccess && hwrite;
    state_d.wrAddr = reg_addr(haddr);
    if (busAccess && !hwrite) begin
      case (reg_addr(haddr))
        ADDR_CTRL: state_d.rdata = ctrlWord;
        ADDR_STATUS: state_d.rdata = statusWord;
        default: state_d.rdata = RDATA_ZERO;
      endcase
    end
    if (ctrlWrite) begin
      state_d.dualRate = hwdata[CTRL_DUAL_BIT];
      state_d.nodeType = lbsn_node_t'(hwdata[CTRL_TYPE_LSB +: 2]);
      if (hwdata[CTRL_NORMAL_BIT]) begin
        state_d.privMode = 1'b0;
      end
    end

    // Character counter steps on every character sent until it holds at all ones
    if (txCharStrobe && state_q.charCnt != '1) begin
      state_d.charCnt = state_q.charCnt + CNT_W'(1);
    end

    case (state_q.fsm)
      // Hold while the line reports a fault
      FSM_FAULT_WAIT: begin
        state_d.txChar = TX_IDLE_SYNC;
        state_d.pstate = PS_DISABLED;
        state_d.charCnt = '0;
        if (!state_q.faultSync) begin
          tmrIf.restart = 1'b1;
          state_d.fsm = FSM_IDLE_SYNC;
        end
      end

      // Idle characters until count and, in dual rate, sync allow
      FSM_IDLE_SYNC: begin
        state_d.txChar = TX_IDLE_SYNC;
        state_d.pstate = PS_DISABLED;
        if (step_due(state_q.dualRate, tmrIf.expired)) begin
          tmrIf.advance = 1'b1;
          state_d.charCnt = '0;
        end else if (state_q.charCnt >= IDLE_SYNC_MIN) begin
          if (!state_q.dualRate || state_q.syncSync) begin
            state_d.fsm = FSM_ENABLED;
            state_d.pstate = PS_ENABLED;
            state_d.txChar = TX_FRAME_GAP;
          end
        end
      end

      // Frame gaps until a gap is decoded
      FSM_ENABLED: begin
        state_d.txChar = TX_FRAME_GAP;
        if (state_q.syncSync && gapRx) begin
          state_d.fsm = FSM_GAP_WAIT;
          state_d.pstate = PS_READY;
          state_d.linkUp = 1'b1;
          state_d.charCnt = '0;
        end else if (step_due(state_q.dualRate, tmrIf.expired)) begin
          tmrIf.advance = 1'b1;
          state_d.fsm = FSM_IDLE_SYNC;
          state_d.pstate = PS_DISABLED;
          state_d.txChar = TX_IDLE_SYNC;
          state_d.charCnt = '0;
        end
      end

      // Minimum run of gaps after link up
      FSM_GAP_WAIT: begin
        state_d.txChar = TX_FRAME_GAP;
        if (state_q.charCnt >= GAP_MIN) begin
          state_d.fsm = FSM_SEND_RR;
        end
      end

      // Offer credit once a buffer is free
      FSM_SEND_RR: begin
        if (bufFree) begin
          state_d.txChar = TX_RECV_READY;
          if (txCharStrobe && state_q.txChar == TX_RECV_READY) begin
            state_d.creditOwed = 1'b0;
            state_d.txChar = TX_FRAME_GAP;
            state_d.fsm = FSM_WAIT_RR;
          end
        end else begin
          state_d.txChar = TX_FRAME_GAP;
        end
      end

      // Await the partner's credit
      FSM_WAIT_RR: begin
        state_d.txChar = TX_FRAME_GAP;
        if (recvReadyRx) begin
          state_d.creditWait = 1'b0;
          state_d.fsm = FSM_ACTIVE;
        end
      end

      // Bring-up complete
      FSM_ACTIVE: begin
        state_d.txChar = TX_FRAME_GAP;
      end

      default: begin
        state_d.fsm = FSM_FAULT_WAIT;
      end
    endcase

    // Restart of bring-up wins over the sequence above
    if (enterDisabled) begin
      state_d.fsm = FSM_FAULT_WAIT;
      state_d.pstate = PS_DISABLED;
      state_d.privMode = 1'b1;
      state_d.linkUp = 1'b0;
      state_d.creditOwed = 1'b1;
      state_d.creditWait = 1'b1;
      state_d.txChar = TX_IDLE_SYNC;
      state_d.charCnt = '0;
    end

    // Token bounce flag, set wins over clear
    if (evSetup && !evBounce && state_q.nodeType == NODE_DUAL
        && state_q.linkUp && state_q.operSync) begin
      state_d.tokenBounce = 1'b0;
    end
    if (state_q.nodeType != NODE_DUAL
        || !state_q.linkUp || !state_q.operSync
        || (evSetup && evBounce)) begin
      state_d.tokenBounce = 1'b1;
    end

    // Received tokens go back or onward
    state_d.tokenBack = tokenRx && state_q.tokenBounce;
    state_d.tokenOn = tokenRx && !state_q.tokenBounce;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= '{
        fsm: FSM_FAULT_WAIT,
        txChar: TX_IDLE_SYNC,
        pstate: PS_DISABLED,
        privMode: 1'b1,
        creditOwed: 1'b1,
        creditWait: 1'b1,
        tokenBounce: 1'b1,
        nodeType: NODE_SINGLE,
        faultMeta: 1'b1,
        faultSync: 1'b1,
        default: '0
      };
    end else begin
      state_q <= state_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_q.rdata;
  assign txChar = state_q.txChar;
  assign rateHigh = tmrIf.rateHigh;
  assign tokenBounceOut = state_q.tokenBack;
  assign tokenForwardOut = state_q.tokenOn;
  assign portState = state_q.pstate;
  assign privMode = state_q.privMode;
  assign linkUp = state_q.linkUp;
  assign creditOwed = state_q.creditOwed;
  assign creditWait = state_q.creditWait;
  assign privFramesOk = (state_q.fsm == FSM_ACTIVE);

endmodule
`default_nettype wire

//--- src/lbsn_pkg.sv
package lbsn_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned STEP0_MS = 400;
  localparam int unsigned STEP1_MS = 200;
  localparam int unsigned STEP2_MS = 100;
  localparam int unsigned STEP3_MS = 300;
  localparam int TMR_W = 24;

  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    return ms * (CLK_HZ / MS_PER_S);
  endfunction

  // Character counts
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] IDLE_SYNC_MIN = 8'hc8;
  localparam logic [CNT_W-1:0] GAP_MIN = 8'h0a;

  // Schedule
  localparam logic [1:0] STEP_FIRST = 2'h0;
  localparam logic [1:0] STEP_LAST = 2'h3;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h08;

  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_TYPE_LSB = 1;
  localparam int CTRL_NORMAL_BIT = 3;

  localparam int EV_POWER_ON_SELF_TEST_BIT = 0;
  localparam int EV_RESET_BIT = 1;
  localparam int EV_ERP_BIT = 2;
  localparam int EV_SETUP_BIT = 3;
  localparam int EV_BOUNCE_BIT = 4;
  localparam int EV_RATE_LSB = 5;
  localparam int EV_RATE_W = 3;

  localparam int ST_FSM_LSB = 0;
  localparam int ST_PSTATE_LSB = 3;
  localparam int ST_STEP_LSB = 5;
  localparam int ST_LINKUP_BIT = 7;
  localparam int ST_OWED_BIT = 8;
  localparam int ST_WAIT_BIT = 9;
  localparam int ST_BOUNCE_BIT = 10;
  localparam int ST_PRIV_BIT = 11;
  localparam int ST_FAULT_BIT = 12;
  localparam int ST_RATE_BIT = 13;

  // Bus
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    NODE_SINGLE = 2'h0,
    NODE_DUAL = 2'h1,
    NODE_SWITCH = 2'h2,
    NODE_RSVD = 2'h3
  } lbsn_node_t;

  typedef enum logic [1:0] {
    TX_IDLE_SYNC = 2'h0,
    TX_FRAME_GAP = 2'h1,
    TX_RECV_READY = 2'h2
  } lbsn_txchar_t;

  typedef enum logic [1:0] {
    PS_DISABLED = 2'h0,
    PS_ENABLED = 2'h1,
    PS_READY = 2'h2
  } lbsn_pstate_t;

  typedef enum logic [2:0] {
    FSM_FAULT_WAIT = 3'h0,
    FSM_IDLE_SYNC = 3'h1,
    FSM_ENABLED = 3'h3,
    FSM_GAP_WAIT = 3'h2,
    FSM_SEND_RR = 3'h6,
    FSM_WAIT_RR = 3'h7,
    FSM_ACTIVE = 3'h5
  } lbsn_fsm_t;

endpackage

//--- src/lbsn_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lbsn_timer_if;
  logic restart;
  logic advance;
  logic expired;
  logic rateHigh;
  logic [1:0] step;

  modport ctrl (output restart, output advance, input expired, input rateHigh, input step);
  modport timer (input restart, input advance, output expired, output rateHigh, output step);
endinterface
`default_nettype wire

//--- src/lbsn_step_timer.sv
`timescale 1ns/1ps
`default_nettype none
module lbsn_step_timer
  import lbsn_pkg::*;
#(
  parameter int unsigned STEP0_CYC = ms_to_cyc(STEP0_MS),
  parameter int unsigned STEP1_CYC = ms_to_cyc(STEP1_MS),
  parameter int unsigned STEP2_CYC = ms_to_cyc(STEP2_MS),
  parameter int unsigned STEP3_CYC = ms_to_cyc(STEP3_MS)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  lbsn_timer_if.timer tmr
);

  typedef struct packed {
    logic [1:0] step;
    logic [TMR_W-1:0] count;
  } lbsn_tmr_state_t;

  lbsn_tmr_state_t state_q;
  lbsn_tmr_state_t state_d;

  // Nominal step length, no deliberate deviation
  function automatic logic [TMR_W-1:0] step_len(input logic [1:0] s);
    case (s)
      2'h0: step_len = TMR_W'(STEP0_CYC - 1);
      2'h1: step_len = TMR_W'(STEP1_CYC - 1);
      2'h2: step_len = TMR_W'(STEP2_CYC - 1);
      default: step_len = TMR_W'(STEP3_CYC - 1);
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    if (tmr.restart) begin
      state_d.step = STEP_FIRST;
      state_d.count = step_len(STEP_FIRST);
    end else if (tmr.advance) begin
      state_d.step = state_q.step + 2'h1;
      state_d.count = step_len(state_q.step + 2'h1);
    end else if (state_q.count != '0) begin
      state_d.count = state_q.count - TMR_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= '{step: STEP_FIRST, count: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign tmr.expired = (state_q.count == '0);
  assign tmr.step = state_q.step;
  assign tmr.rateHigh = ~state_q.step[0];

endmodule
`default_nettype wire

//--- verification/lbsn_link_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lbsn_link_port_monitor
  import lbsn_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic hreadyout,
  input wire logic hresp,
  // Link
  input wire logic lineFault,
  input wire logic gapRx,
  input wire logic recvReadyRx,
  input wire logic tokenRx,
  input wire logic txCharStrobe,
  input wire logic bufFree,
  input wire lbsn_txchar_t txChar,
  input wire logic rateHigh,
  input wire logic tokenBounceOut,
  input wire logic tokenForwardOut,
  // Status
  input wire lbsn_pstate_t portState,
  input wire logic linkUp,
  input wire logic creditOwed,
  input wire logic creditWait,
  input wire logic privFramesOk
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [8:0] idleCnt_q;
  logic [CNT_W-1:0] gapCnt_q;
  logic rate_q;
  // Idle and gap characters sent in the current phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idleCnt_q <= 9'h000;
      gapCnt_q <= '0;
      rate_q <= 1'b1;
    end else begin
      rate_q <= rateHigh;
      if (lineFault || portState != PS_DISABLED) begin
        idleCnt_q <= 9'h000;
      end else if (rateHigh != rate_q) begin
        idleCnt_q <= {8'h00, txCharStrobe && txChar == TX_IDLE_SYNC};
      end else if (txCharStrobe && txChar == TX_IDLE_SYNC && idleCnt_q != 9'h1ff) begin
        idleCnt_q <= idleCnt_q + 9'h001;
      end
      if (!linkUp) begin
        gapCnt_q <= '0;
      end else if (txCharStrobe && txChar == TX_FRAME_GAP && gapCnt_q != 8'hff) begin
        gapCnt_q <= gapCnt_q + 8'h01;
      end
    end
  end
  sequence credit_given;
    txCharStrobe && txChar == TX_RECV_READY;
  endsequence
  sequence remote_credit;
    recvReadyRx && linkUp && !creditOwed && creditWait;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  enable_count_a: assert property ($rose(portState == PS_ENABLED) |->
    idleCnt_q >= {1'b0, IDLE_SYNC_MIN}) else $error("enabled too early");
  ready_link_a: assert property ($rose(linkUp) |->
    portState == PS_READY && $past(gapRx)) else $error("link up without gap");
  gap_lead_a: assert property ($rose(txChar == TX_RECV_READY) |->
    gapCnt_q >= GAP_MIN) else $error("ready pair too early");
  rr_buffer_a: assert property ($rose(txChar == TX_RECV_READY) |->
    $past(bufFree) && linkUp && creditOwed) else $error("ready pair without buffer");
  credit_step_a: assert property (credit_given |=>
    !creditOwed && txChar == TX_FRAME_GAP) else $error("owed flag not cleared");
  remote_credit_a: assert property (remote_credit |=>
    !creditWait && privFramesOk) else $error("wait flag not cleared");
  frames_ok_a: assert property (privFramesOk |->
    linkUp && !creditOwed && !creditWait) else $error("frames allowed too early");
  token_route_a: assert property (tokenRx |=>
    tokenBounceOut != tokenForwardOut) else $error("token not routed once");
  step_entry_a: assert property ($changed(rateHigh) |-> ##[0:2]
    (portState == PS_DISABLED && txChar == TX_IDLE_SYNC)) else $error("step not disabled");
  enabled_gap_a: assert property (portState == PS_ENABLED |->
    txChar == TX_FRAME_GAP) else $error("enabled without gaps");
endmodule
bind lbsn_link_port lbsn_link_port_monitor lbsn_link_port_monitor_i (.sys_clk, .rst,
  .hreadyout, .hresp, .lineFault, .gapRx, .recvReadyRx, .tokenRx, .txCharStrobe, .bufFree,
  .txChar, .rateHigh, .tokenBounceOut, .tokenForwardOut, .portState, .linkUp, .creditOwed,
  .creditWait, .privFramesOk);
`default_nettype wire

//--- verification/lbsn_remote_port.sv
`timescale 1ns/1ps
`default_nettype none
module lbsn_remote_port
  import lbsn_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Test control
  input wire logic syncOn,
  input wire logic [4:0] rrDelay,
  // Local port
  input wire lbsn_txchar_t txChar,
  output logic txCharStrobe,
  output logic charSync,
  output logic gapRx,
  output logic recvReadyRx
);
  logic [3:0] ph;
  logic [4:0] rrCnt;
  logic rrSeen;
  assign charSync = syncOn;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph <= 4'h0;
      rrCnt <= 5'h00;
      rrSeen <= 1'b0;
      txCharStrobe <= 1'b0;
      gapRx <= 1'b0;
      recvReadyRx <= 1'b0;
    end else begin
      ph <= ph + 4'h1;
      txCharStrobe <= ph[0];
      gapRx <= syncOn && ph == 4'h7;
      if (txChar == TX_IDLE_SYNC) begin
        rrSeen <= 1'b0;
        rrCnt <= 5'h00;
      end else if (txCharStrobe && txChar == TX_RECV_READY) begin
        rrSeen <= 1'b1;
      end else if (rrSeen && rrCnt != 5'h1f) begin
        rrCnt <= rrCnt + 5'h01;
      end
      recvReadyRx <= rrSeen && rrCnt == rrDelay;
    end
  end
endmodule
`default_nettype wire

//--- verification/test_link_bringup_speed_negotiation.sv
`timescale 1ns/1ps
`default_nettype none
module test_link_bringup_speed_negotiation
  import lbsn_pkg::*;
;
  localparam int S0 = 4000, S1 = 2000, S2 = 1000, S3 = 3000;
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic lineFault = 1, otherPortOper = 0, tokenRx = 0, bufFree = 0, syncOn = 0;
  logic [4:0] rrDelay = 5'h02;
  logic charSync, gapRx, recvReadyRx, txCharStrobe, rateHigh, r;
  logic tokenBounceOut, tokenForwardOut, privMode, linkUp, creditOwed, creditWait;
  logic privFramesOk;
  lbsn_txchar_t txChar;
  lbsn_pstate_t portState;
  int mismatches = 0, n_tests = 0, cyc = 0, t;
  int nom[5] = '{S0, S1, S2, S3, S0};
  logic [31:0] ev[5] = '{32'h01, 32'h02, 32'h04, 32'h28, 32'h08};
  assign hready = hreadyout;
  always #12.5 sys_clk = ~sys_clk;
  lbsn_link_port #(.STEP0_CYC(S0), .STEP1_CYC(S1), .STEP2_CYC(S2), .STEP3_CYC(S3))
    lbsn_link_port_i (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .lineFault, .charSync, .otherPortOper, .gapRx,
    .recvReadyRx, .tokenRx, .txCharStrobe, .bufFree, .txChar, .rateHigh, .tokenBounceOut,
    .tokenForwardOut, .portState, .privMode, .linkUp, .creditOwed, .creditWait,
    .privFramesOk);
  lbsn_remote_port lbsn_remote_port_i (.sys_clk, .rst, .syncOn, .rrDelay, .txChar,
    .txCharStrobe, .charSync, .gapRx, .recvReadyRx);
  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic tok(input logic exp);
    tick(2);
    tokenRx <= 1;
    @(posedge sys_clk);
    tokenRx <= 0;
    @(posedge sys_clk);
    chk("bounce", tokenBounceOut, exp);
    chk("forward", tokenForwardOut, !exp);
  endtask
  task automatic bring;
    do @(posedge sys_clk); while (privFramesOk !== 1'b1);
    chk("ready", portState, PS_READY);
  endtask
  initial begin
    tick(5);
    rst <= 0;
    @(posedge sys_clk);
    chk("state", portState, PS_DISABLED);
    chk("priv", {privMode, linkUp, creditOwed, creditWait, rateHigh}, 5'h17);
    bus(0, ADDR_STATUS, 0);
    chk("bounce flag", d[ST_BOUNCE_BIT], 1);
    bus(0, 8'hfc, 0);
    chk("unmapped", d, 0);
    tok(1);
    tick(100);
    chk("fault tx", txChar, TX_IDLE_SYNC);
    bus(0, ADDR_STATUS, 0);
    chk("fault fsm", d[2:0], FSM_FAULT_WAIT);
    lineFault <= 0;
    do @(posedge sys_clk); while (portState !== PS_ENABLED);
    chk("enabled tx", txChar, TX_FRAME_GAP);
    syncOn <= 1;
    do @(posedge sys_clk); while (linkUp !== 1'b1);
    tick(200);
    chk("stalled", {creditOwed, txChar}, {1'b1, TX_FRAME_GAP});
    bufFree <= 1;
    bring();
    otherPortOper <= 1;
    bus(1, ADDR_CTRL, 32'h2);
    bus(1, ADDR_EVENT, 32'h08);
    tok(0);
    bus(1, ADDR_CTRL, 32'h4);
    tok(1);
    bus(1, ADDR_CTRL, 32'h2);
    bus(1, ADDR_EVENT, 32'h18);
    tok(1);
    bus(1, ADDR_EVENT, 32'h08);
    tok(0);
    otherPortOper <= 0;
    tick(2);
    tok(1);
    bus(1, ADDR_CTRL, 32'h8);
    tick(2);
    chk("normal", privMode, 0);
    for (int i = 0; i < 5; i++) begin
      bring();
      bus(1, ADDR_EVENT, ev[i]);
      tick(2);
      chk("link", linkUp, i == 4);
      chk("priv", privMode, 1);
    end
    syncOn <= 0;
    bus(1, ADDR_CTRL, 32'h1);
    bus(1, ADDR_EVENT, 32'h01);
    t = cyc;
    chk("first step", rateHigh, 1);
    for (int i = 0; i < 5; i++) begin
      r = rateHigh;
      do @(posedge sys_clk); while (rateHigh === r);
      chk("step", (cyc - t) * 10 >= nom[i] * 9 && (cyc - t) * 10 <= nom[i] * 11, 1);
      t = cyc;
    end
    rrDelay <= 5'h1e;
    syncOn <= 1;
    do @(posedge sys_clk); while (portState !== PS_ENABLED);
    chk("dual enabled", txChar, TX_FRAME_GAP);
    bring();
    bus(1, ADDR_EVENT, 32'h28);
    tick(2);
    chk("restart", {rateHigh, portState}, {1'b1, PS_DISABLED});
    close_out();
  end
endmodule
`default_nettype wire
